// ---- bfd_defines.svh ----
// Purpose: named constants for the flash bus operation decoder
// Assumes: included by the package and by every design file that needs a figure
// Notes: widths follow the 1M x 32 array organisation
`ifndef BFD_DEFINES_SVH
`define BFD_DEFINES_SVH

// bus geometry
`define BFD_ADDR_W 20
`define BFD_DATA_W 32
`define BFD_ADDR_ONE 20'h00001
`define BFD_ADDR_ZERO 20'h00000
`define BFD_WORD_ZERO 32'h00000000

// bank select bits and ordering options
`define BFD_BANK_HI 19
`define BFD_BANK_LO 18
`define BFD_OPT_00 2'h0
`define BFD_OPT_01 2'h1

// protection status read
`define BFD_ID_HI 7
`define BFD_ID_LO 0
`define BFD_ID_CODE 8'h02
`define BFD_PROT_PAD 30'h00000000

// outermost boot sectors, two 2K-word sectors at the top end under option 00, the bottom end under 01
`define BFD_BOOT_HI 19
`define BFD_BOOT_LO 12
`define BFD_BOOT_TOP 8'hFF
`define BFD_BOOT_BOT 8'h00

// command that returns the mode machine to array read
`define BFD_CMD_HI 7
`define BFD_CMD_LO 0
`define BFD_CMD_READ_RESET 8'hF0

`endif

// ---- bfd_pkg.sv ----
// Purpose: types shared by the flash bus operation decoder
// Assumes: bfd_defines.svh is on the include path
// Notes: packed structs carry pin groups, command latches and engine status
`include "bfd_defines.svh"

package bfd_pkg;

   typedef enum logic [2:0] {
      BFD_OP_RESET,
      BFD_OP_STANDBY,
      BFD_OP_WRITE,
      BFD_OP_LOAD,
      BFD_OP_PROT,
      BFD_OP_READ,
      BFD_OP_OUT_DIS,
      BFD_OP_IDLE
   } bfd_op_type;

   typedef enum logic {
      BFD_MD_ARRAY,
      BFD_MD_CMD
   } bfd_mode_type;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic address_load_n;
      logic rst_n;
      logic wp_n;
      logic id_high_voltage;
      logic [`BFD_ADDR_W-1:0] addr;
      logic [`BFD_DATA_W-1:0] data;
   } bfd_pins_type;

   typedef struct packed {
      logic [`BFD_ADDR_W-1:0] addr;
      logic [`BFD_DATA_W-1:0] data;
      logic bank;
      logic blocked;
   } bfd_cmd_type;

   typedef struct packed {
      logic [1:0] bank_busy;
      logic erase_susp;
      logic [`BFD_ADDR_W-1:0] erase_base;
      logic [`BFD_ADDR_W-1:0] erase_mask;
      logic no_concurrent;
      logic protect_op;
   } bfd_embed_type;

endpackage

// ---- bfd_sync3.sv ----
// Purpose: three-flop synchroniser with agreement filter
// Assumes: d_i comes from outside the clk_i domain
// Notes: the output moves only when the second and third stages agree
`timescale 1ns/1ps

module bfd_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
         end
      end
   end

   assign q_o = q_reg;

endmodule

// ---- bfd_bank_dec.sv ----
// Purpose: bank decode from the bank select bits and the ordering option
// Assumes: option values other than 01 behave as 00
// Notes: purely combinational
`timescale 1ns/1ps
`include "bfd_defines.svh"

module bfd_bank_dec (
   // decode inputs
   input wire logic [1:0] opt_i,
   input wire logic [1:0] bank_select_bits_i,
   // decode outputs
   output logic bank_o,
   output logic small_o
);

   wire opt01_w = (opt_i == `BFD_OPT_01);
   wire bank_opt00_w = |bank_select_bits_i;
   wire bank_opt01_w = &bank_select_bits_i;

   assign bank_o = opt01_w ? bank_opt01_w : bank_opt00_w;
   // small bank is bank 0 under 00, bank 1 under 01
   assign small_o = (bank_o == opt01_w);

endmodule

// ---- bfd_flash_bus_decode.sv ----
// Purpose: bus operation decode, burst address and bank routing of a burst flash
// Assumes: array_data_i answers array_addr_o in the same cycle; bus_clk_i is the host burst clock
// Notes: pins are filtered through three flops; burst addresses cross by toggle plus held word
`timescale 1ns/1ps
`include "bfd_defines.svh"

// How it works
// - chip enable and output gate low, write strobe, load and reset high, drives the word.
// - chip enable low, gate high, strobe low is a write; clock and load optional.
// - data lines float in standby, output disable and reset.
// - writes land in command latches holding address and data that feed the mode machine.
// - reset puts the mode machine into array read.
// - array read holds until a write changes the command latches.
// - protection read returns persistent bit on bit 0, dynamic bit on bit 1.
// - chip enable low, strobe high, load low takes a burst start address.
// - load high with gate low advances the burst one word per clock.
// - chip enable high or reset low ends the burst and floats the lines.
// - a new load during a burst restarts from the new address.
// - reads in the idle bank proceed while the other bank runs an embedded job.
// - option 00 makes bank 0 small; option 01 makes bank 0 big.
// - under option 00 top bits 00 select bank 0, others bank 1.
// - under option 01 top bits 11 select bank 1, others bank 0.
// - during erase suspend the erasing sector alone is off limits in its bank.
// - concurrency rules apply equally to the secured one-time sector.
// - no concurrent bank access during query or password program and verify.
// - during protect-bit jobs big bank reads array, small bank reads status.
// - write protect blocks program and erase of the two outermost boot sectors.
// - reset low aborts everything and floats the data lines throughout.
module bfd_flash_bus_decode (
   // core clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host burst clock
   input wire logic bus_clk_i,
   // host pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic address_load_n_i,
   input wire logic reset_pin_n_i,
   input wire logic wp_n_i,
   input wire logic id_high_voltage_i,
   input wire logic [`BFD_ADDR_W-1:0] addr_i,
   input wire logic [`BFD_DATA_W-1:0] data_lines_i,
   output logic [`BFD_DATA_W-1:0] data_lines_o,
   output logic data_lines_oe_o,
   // ordering option strap
   input wire logic [1:0] opt_i,
   // array and embedded engine
   output logic [`BFD_ADDR_W-1:0] array_addr_o,
   output logic array_otp_o,
   input wire logic [`BFD_DATA_W-1:0] array_data_i,
   input wire logic [`BFD_DATA_W-1:0] status_i,
   input wire logic persistent_protect_bit_i,
   input wire logic dynamic_protect_bit_i,
   input wire logic secured_otp_sector_i,
   input wire bfd_pkg::bfd_embed_type embed_i,
   // command latches and decode state
   output bfd_pkg::bfd_cmd_type cmd_o,
   output logic cmd_stb_o,
   output bfd_pkg::bfd_op_type bus_op_o,
   output bfd_pkg::bfd_mode_type mode_o,
   output logic bank_o,
   output logic burst_active_o
);
   import bfd_pkg::*;

   localparam bfd_pins_type PINS_RST = '{
      ce_n: '1, oe_n: '1, we_n: '1, address_load_n: '1, rst_n: '0,
      wp_n: '1, id_high_voltage: '0, addr: '0, data: '0};

   // ---- link side, on the host burst clock ----
   logic lk_rst_s1_reg;
   logic lk_rst_s2_reg;
   logic lk_active_reg;
   logic lk_tgl_reg;
   logic [`BFD_ADDR_W-1:0] lk_addr_reg;

   always_ff @(posedge bus_clk_i) begin
      lk_rst_s1_reg <= rst_n_i;
      lk_rst_s2_reg <= lk_rst_s1_reg;
   end

   wire lk_kill_w = !lk_rst_s2_reg || !reset_pin_n_i || ce_n_i;
   wire lk_load_w = we_n_i && !address_load_n_i;
   wire lk_adv_w = we_n_i && address_load_n_i && !oe_n_i && lk_active_reg;

   always_ff @(posedge bus_clk_i) begin
      if (!lk_rst_s2_reg) begin
         lk_tgl_reg <= '0;
         lk_addr_reg <= `BFD_ADDR_ZERO;
      end else if (!lk_kill_w && lk_load_w) begin
         lk_tgl_reg <= !lk_tgl_reg;
         lk_addr_reg <= addr_i;
      end else if (!lk_kill_w && lk_adv_w) begin
         lk_tgl_reg <= !lk_tgl_reg;
         lk_addr_reg <= lk_addr_reg + `BFD_ADDR_ONE;
      end
   end

   always_ff @(posedge bus_clk_i) begin
      if (lk_kill_w) begin
         lk_active_reg <= '0;
      end else if (lk_load_w) begin
         lk_active_reg <= '1;
      end
   end

   // ---- core side ----
   bfd_pins_type pins_raw_w;
   bfd_pins_type pins_w;
   logic tgl_sync_w;

   assign pins_raw_w = '{
      ce_n: ce_n_i, oe_n: oe_n_i, we_n: we_n_i, address_load_n: address_load_n_i,
      rst_n: reset_pin_n_i, wp_n: wp_n_i, id_high_voltage: id_high_voltage_i,
      addr: addr_i, data: data_lines_i};

   bfd_sync3 #(
      .W($bits(bfd_pins_type)),
      .RST_VAL(PINS_RST)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(pins_raw_w),
      .q_o(pins_w)
   );

   bfd_sync3 #(
      .W(1),
      .RST_VAL(1'b0)
   ) u_tgl_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(lk_tgl_reg),
      .q_o(tgl_sync_w)
   );

   // operation decode, reset first
   wire op_reset_w = !pins_w.rst_n;
   wire op_standby_w = pins_w.ce_n;
   wire op_write_w = pins_w.oe_n && !pins_w.we_n;
   wire op_load_w = pins_w.we_n && !pins_w.address_load_n;
   wire id_addr_w = pins_w.addr[`BFD_ID_HI:`BFD_ID_LO] == `BFD_ID_CODE;
   wire op_prot_w = !pins_w.oe_n && pins_w.we_n && pins_w.id_high_voltage && id_addr_w;
   wire op_read_w = !pins_w.oe_n && pins_w.we_n;
   wire op_outdis_w = pins_w.oe_n && pins_w.we_n;

   bfd_op_type op_w;
   assign op_w = op_reset_w ? BFD_OP_RESET :
                 op_standby_w ? BFD_OP_STANDBY :
                 op_write_w ? BFD_OP_WRITE :
                 op_load_w ? BFD_OP_LOAD :
                 op_prot_w ? BFD_OP_PROT :
                 op_read_w ? BFD_OP_READ :
                 op_outdis_w ? BFD_OP_OUT_DIS : BFD_OP_IDLE;

   // strap and burst state
   logic [1:0] opt_reg;
   logic tgl_prev_reg;
   logic burst_active_reg;
   logic [`BFD_ADDR_W-1:0] burst_addr_reg;
   wire burst_evt_w = tgl_sync_w != tgl_prev_reg;
   wire burst_end_w = (op_w == BFD_OP_RESET) || (op_w == BFD_OP_STANDBY);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         opt_reg <= opt_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tgl_prev_reg <= '0;
         burst_active_reg <= '0;
         burst_addr_reg <= `BFD_ADDR_ZERO;
      end else begin
         tgl_prev_reg <= tgl_sync_w;
         if (burst_evt_w) begin
            burst_addr_reg <= lk_addr_reg;
         end
         if (burst_end_w) begin
            burst_active_reg <= '0;
         end else if (burst_evt_w) begin
            burst_active_reg <= '1;
         end
      end
   end

   // read routing and bank concurrency
   wire [`BFD_ADDR_W-1:0] rd_addr_w = burst_active_reg ? burst_addr_reg : pins_w.addr;
   logic rd_bank_w;
   logic rd_small_w;
   logic wr_bank_w;
   logic wr_small_w;

   bfd_bank_dec u_rd_bank (
      .opt_i(opt_reg),
      .bank_select_bits_i(rd_addr_w[`BFD_BANK_HI:`BFD_BANK_LO]),
      .bank_o(rd_bank_w),
      .small_o(rd_small_w)
   );

   bfd_mode_type mode_reg;
   bfd_mode_type mode_next;
   wire any_busy_w = |embed_i.bank_busy;
   wire rd_busy_w = embed_i.bank_busy[rd_bank_w];
   wire rd_in_erase_w = (rd_addr_w & embed_i.erase_mask)
                        == (embed_i.erase_base & embed_i.erase_mask);
   wire status_sel_w = (mode_reg == BFD_MD_CMD)
                       || (embed_i.no_concurrent && any_busy_w)
                       || (embed_i.protect_op ? rd_small_w : rd_busy_w)
                       || (embed_i.erase_susp && rd_in_erase_w);
   wire [`BFD_DATA_W-1:0] prot_word_w = {`BFD_PROT_PAD, dynamic_protect_bit_i,
                                         persistent_protect_bit_i};
   wire drive_w = (op_w == BFD_OP_READ) || (op_w == BFD_OP_PROT);
   wire [`BFD_DATA_W-1:0] data_next = (op_w == BFD_OP_PROT) ? prot_word_w :
                                      status_sel_w ? status_i : array_data_i;

   logic [`BFD_DATA_W-1:0] data_reg;
   logic data_oe_reg;
   logic [`BFD_ADDR_W-1:0] array_addr_reg;
   logic array_otp_reg;
   logic bank_reg;
   bfd_op_type op_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_reg <= `BFD_WORD_ZERO;
         data_oe_reg <= '0;
         array_addr_reg <= `BFD_ADDR_ZERO;
         array_otp_reg <= '0;
         bank_reg <= '0;
         op_reg <= BFD_OP_RESET;
      end else begin
         data_reg <= drive_w ? data_next : `BFD_WORD_ZERO;
         data_oe_reg <= drive_w;
         array_addr_reg <= rd_addr_w;
         array_otp_reg <= secured_otp_sector_i;
         bank_reg <= rd_bank_w;
         op_reg <= op_w;
      end
   end

   // command latches
   logic wr_seen_reg;
   logic [`BFD_ADDR_W-1:0] wr_addr_reg;
   logic [`BFD_DATA_W-1:0] wr_data_reg;
   bfd_cmd_type cmd_reg;
   logic cmd_stb_reg;

   bfd_bank_dec u_wr_bank (
      .opt_i(opt_reg),
      .bank_select_bits_i(wr_addr_reg[`BFD_BANK_HI:`BFD_BANK_LO]),
      .bank_o(wr_bank_w),
      .small_o(wr_small_w)
   );

   wire [7:0] wr_boot_w = wr_addr_reg[`BFD_BOOT_HI:`BFD_BOOT_LO];
   wire boot_edge_w = (opt_reg == `BFD_OPT_01) ? (wr_boot_w == `BFD_BOOT_BOT)
                                               : (wr_boot_w == `BFD_BOOT_TOP);
   wire wr_in_erase_w = (wr_addr_reg & embed_i.erase_mask)
                        == (embed_i.erase_base & embed_i.erase_mask);
   wire wr_blocked_w = (!pins_w.wp_n && boot_edge_w && !wr_small_w)
                       || (embed_i.erase_susp && wr_in_erase_w);
   wire wr_end_w = wr_seen_reg && (op_w != BFD_OP_WRITE) && (op_w != BFD_OP_RESET);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_seen_reg <= '0;
         wr_addr_reg <= `BFD_ADDR_ZERO;
         wr_data_reg <= `BFD_WORD_ZERO;
         cmd_reg <= '0;
         cmd_stb_reg <= '0;
      end else begin
         wr_seen_reg <= (op_w == BFD_OP_WRITE);
         if (op_w == BFD_OP_WRITE) begin
            wr_addr_reg <= pins_w.addr;
            wr_data_reg <= pins_w.data;
         end
         cmd_stb_reg <= wr_end_w;
         if (wr_end_w) begin
            cmd_reg <= '{addr: wr_addr_reg, data: wr_data_reg,
                         bank: wr_bank_w, blocked: wr_blocked_w};
         end
      end
   end

   // mode machine fed by the command latches
   wire rr_cmd_w = cmd_reg.data[`BFD_CMD_HI:`BFD_CMD_LO] == `BFD_CMD_READ_RESET;

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         BFD_MD_ARRAY: begin
            if (cmd_stb_reg && !rr_cmd_w) begin
               mode_next = BFD_MD_CMD;
            end
         end
         BFD_MD_CMD: begin
            if (cmd_stb_reg && rr_cmd_w) begin
               mode_next = BFD_MD_ARRAY;
            end
         end
         default: begin
            mode_next = BFD_MD_ARRAY;
         end
      endcase
      if (op_w == BFD_OP_RESET) begin
         mode_next = BFD_MD_ARRAY;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_reg <= BFD_MD_ARRAY;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign data_lines_o = data_reg;
   assign data_lines_oe_o = data_oe_reg;
   assign array_addr_o = array_addr_reg;
   assign array_otp_o = array_otp_reg;
   assign cmd_o = cmd_reg;
   assign cmd_stb_o = cmd_stb_reg;
   assign bus_op_o = op_reg;
   assign mode_o = mode_reg;
   assign bank_o = bank_reg;
   assign burst_active_o = burst_active_reg;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_write_end;
      (op_w == BFD_OP_WRITE) ##1 (op_w != BFD_OP_WRITE && op_w != BFD_OP_RESET);
   endsequence

   sequence s_burst_stop;
      burst_active_reg ##0 burst_end_w;
   endsequence

   AST_RESET_FLOAT: assert property (op_reset_w |=> !data_lines_oe_o)
      else $error("data lines driven during hardware reset");
   AST_STANDBY_FLOAT: assert property (op_w == BFD_OP_STANDBY |=> !data_lines_oe_o)
      else $error("data lines driven in standby");
   AST_READ_DRIVE: assert property (op_w == BFD_OP_READ |=> data_lines_oe_o
                                    && bus_op_o == BFD_OP_READ)
      else $error("read did not drive data lines");
   AST_RESET_ARRAY: assert property (op_reset_w |=> mode_o == BFD_MD_ARRAY)
      else $error("reset left mode machine out of array read");
   AST_MODE_HOLD: assert property (mode_o == BFD_MD_ARRAY && !cmd_stb_o
                                   |=> mode_o == BFD_MD_ARRAY)
      else $error("array read mode left without a write");
   AST_CMD_LATCH: assert property (s_write_end |=> cmd_stb_o
                                   && cmd_o.data == $past(wr_data_reg))
      else $error("write did not reach the command latches");
   AST_PROT_WORD: assert property (op_w == BFD_OP_PROT |=> data_lines_o
                                   == {`BFD_PROT_PAD, $past(dynamic_protect_bit_i),
                                   $past(persistent_protect_bit_i)})
      else $error("protection status word wrong");
   AST_BURST_END: assert property (s_burst_stop |=> !burst_active_o && !data_lines_oe_o)
      else $error("burst not ended by chip enable or reset");
   AST_BANK_00: assert property (opt_reg == `BFD_OPT_00
                                 && rd_addr_w[`BFD_BANK_HI:`BFD_BANK_LO] == 2'h0
                                 |=> !bank_o)
      else $error("option 00 bank decode wrong");
   AST_BANK_01: assert property (opt_reg == `BFD_OPT_01
                                 && rd_addr_w[`BFD_BANK_HI:`BFD_BANK_LO] == 2'h2
                                 |=> !bank_o)
      else $error("option 01 bank decode wrong");
   AST_BUSY_STATUS: assert property (op_w == BFD_OP_READ && rd_busy_w && !embed_i.protect_op
                                     |=> data_lines_o == $past(status_i))
      else $error("busy bank read did not return status");
   AST_WP_BLOCK: assert property (wr_end_w && !pins_w.wp_n && boot_edge_w && !wr_small_w
                                  |=> cmd_o.blocked)
      else $error("protected boot sector write not blocked");

endmodule

// ---- bfd_array_model.sv ----
// Purpose: array model at the far side of the decoder's array port
// Assumes: the array answers in the same cycle as the address it is given
// Notes: every word carries its own address, so a wrong address shows up as wrong data
`timescale 1ns/1ps
`include "bfd_defines.svh"

module bfd_array_model (
   // array port
   input wire logic [`BFD_ADDR_W-1:0] array_addr_i,
   output logic [`BFD_DATA_W-1:0] array_data_o
);
   assign array_data_o = {12'hC3A, array_addr_i};
endmodule

// ---- flash_bus_operation_decode_tb.sv ----
// Purpose: self-checking bench for the flash bus operation decoder
// Assumes: pin changes pass the core filter within ten core clocks
// Notes: reads and commands are noted in queues and compared when they appear
`timescale 1ns/1ps
`include "bfd_defines.svh"

module flash_bus_operation_decode_tb;
   import bfd_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic bus_clk = 1'b0;
   logic ce_n = 1'b1;
   logic oe_n = 1'b1;
   logic we_n = 1'b1;
   logic adv_n = 1'b1;
   logic rpin_n = 1'b1;
   logic idhv = 1'b0;
   logic persistent_protect_bit = 1'b0;
   logic dynamic_protect_bit = 1'b0;
   logic look = 1'b0;
   logic [1:0] opt = 2'h0;
   logic [`BFD_ADDR_W-1:0] addr = `BFD_ADDR_ZERO;
   logic [`BFD_DATA_W-1:0] wdata = `BFD_WORD_ZERO;
   logic [`BFD_DATA_W-1:0] status = `BFD_WORD_ZERO;
   logic [31:0] rnd = 32'h000170B3;
   bfd_embed_type embed = '0;
   logic [`BFD_ADDR_W-1:0] arr_addr;
   logic [`BFD_DATA_W-1:0] arr_data;
   logic [`BFD_DATA_W-1:0] dout;
   logic oe_o, cmd_stb, bank, bact, otp_o;
   logic wp_n = 1'b1;
   logic otp = 1'b0;
   bfd_cmd_type cmd;
   bfd_op_type op;
   bfd_mode_type mode;
   int err_total = 0;
   int checked = 0;
   logic [32:0] note;
   logic [32:0] rd_q[$];
   logic [32:0] cmd_q[$];
   logic [2:0] fl [3] = '{3'h5, 3'h3, 3'h0};

   always #2 clk_i = ~clk_i;

   bfd_flash_bus_decode dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_clk_i(bus_clk), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .address_load_n_i(adv_n), .reset_pin_n_i(rpin_n), .wp_n_i(wp_n),
      .id_high_voltage_i(idhv), .addr_i(addr), .data_lines_i(wdata), .data_lines_o(dout),
      .data_lines_oe_o(oe_o), .opt_i(opt), .array_addr_o(arr_addr), .array_otp_o(otp_o),
      .array_data_i(arr_data), .status_i(status), .persistent_protect_bit_i(persistent_protect_bit),
      .dynamic_protect_bit_i(dynamic_protect_bit), .secured_otp_sector_i(otp), .embed_i(embed),
      .cmd_o(cmd), .cmd_stb_o(cmd_stb), .bus_op_o(op), .mode_o(mode), .bank_o(bank),
      .burst_active_o(bact));

   bfd_array_model model (.array_addr_i(arr_addr), .array_data_o(arr_data));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [31:0] word(input logic [19:0] a);
      return {12'hC3A, a};
   endfunction

   function automatic logic bank_of(input logic [1:0] o, input logic [1:0] b);
      return (o == `BFD_OPT_01) ? (b == 2'h3) : (b != 2'h0);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic pins(input logic c, input logic o, input logic w, input logic a);
      @(posedge clk_i);
      ce_n <= c;
      oe_n <= o;
      we_n <= w;
      adv_n <= a;
   endtask

   // link clock runs only during resets and burst frames, off the core clock edges
   task automatic bclk(input int n);
      #1;
      repeat (n) begin
         #24 bus_clk = 1'b1;
         #24 bus_clk = 1'b0;
      end
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      int i;
      rd_q.push_back({bank_of(opt, a[19:18]), exp});
      tick(10);
      for (i = 0; i < 40 && oe_o !== 1'b1; i++) tick(1);
      if (i == 40) begin
         err_total++;
         $display("Error data_lines_oe_o expected 1 seen 0");
         test_done();
      end
      look <= 1'b1;
      tick(1);
      look <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] d, input logic blk);
      wdata <= d;
      cmd_q.push_back({blk, d});
      pins(1'b0, 1'b1, 1'b0, 1'b1);
      tick(12);
      pins(1'b0, 1'b1, 1'b1, 1'b1);
      tick(12);
   endtask

   // the link reset needs link clock edges, so the reset lasts until both are done
   task automatic do_reset(input logic [1:0] o);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      opt <= o;
      fork
         tick(20);
         bclk(3);
      join
      cmp("data_lines_oe_o", 32'h0, {31'h0, oe_o});
      cmp("mode_o", {31'h0, BFD_MD_ARRAY}, {31'h0, mode});
      cmp("bus_op_o", {29'h0, BFD_OP_RESET}, {29'h0, op});
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      // the link side sees the release only through its own clock edges
      fork
         tick(8);
         bclk(3);
      join
   endtask

   // address lines carry junk while advancing, the burst must ignore it
   task automatic burst(input logic [19:0] a, input int n);
      addr <= a;
      pins(1'b0, 1'b0, 1'b1, 1'b0);
      bclk(1);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      addr <= ~a;
      bclk(n);
      rd(a + 20'(n), word(a + 20'(n)));
   endtask

   always @(posedge clk_i) begin
      if (look && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         cmp("data_lines_o", note[31:0], dout);
         cmp("bank_o", {31'h0, note[32]}, {31'h0, bank});
      end
      if (cmd_stb && cmd_q.size() > 0) begin
         note = cmd_q.pop_front();
         cmp("cmd_o.data", note[31:0], cmd.data);
         cmp("cmd_o.blocked", {31'h0, note[32]}, {31'h0, cmd.blocked});
      end else if (cmd_stb) begin
         err_total++;
         $display("Error cmd_stb_o expected 0 seen 1");
      end
   end

   initial begin
      int o;
      int b;
      logic [19:0] a;
      for (o = 1; o >= 0; o--) begin
         do_reset(o[1:0]);
         pins(1'b0, 1'b0, 1'b1, 1'b1);
         for (b = 0; b < 4; b++) begin
            rnd = lfsr(rnd);
            a = {b[1:0], rnd[17:0]};
            addr <= a;
            rd(a, word(a));
         end
      end
      idhv <= 1'b1;
      for (b = 0; b < 4; b++) begin
         a = {rnd[19:8], `BFD_ID_CODE};
         {dynamic_protect_bit, persistent_protect_bit} <= b[1:0];
         addr <= a;
         rd(a, {30'h0, b[1:0]});
      end
      idhv <= 1'b0;
      embed.bank_busy <= 2'h1;
      status <= rnd;
      a = {2'h1, rnd[17:0]};
      addr <= a;
      rd(a, word(a));
      a = {2'h0, rnd[17:0]};
      addr <= a;
      rd(a, rnd);
      embed.bank_busy <= 2'h0;
      embed.protect_op <= 1'b1;
      rd(a, rnd);
      embed.protect_op <= 1'b0;
      embed.no_concurrent <= 1'b1;
      embed.bank_busy <= 2'h1;
      a = {2'h1, rnd[17:0]};
      addr <= a;
      rd(a, rnd);
      embed.no_concurrent <= 1'b0;
      embed.bank_busy <= 2'h0;
      embed.erase_susp <= 1'b1;
      embed.erase_base <= a;
      embed.erase_mask <= 20'hFFFFF;
      rd(a, rnd);
      embed.erase_susp <= 1'b0;
      a = {2'h0, rnd[17:0]};
      addr <= a;
      rnd = lfsr(rnd);
      wr({rnd[31:8], 8'h5A}, 1'b0);
      cmp("mode_o", {31'h0, BFD_MD_CMD}, {31'h0, mode});
      status <= rnd;
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      rd(a, rnd);
      for (b = 0; b < 3; b++) begin
         @(posedge clk_i);
         {ce_n, oe_n, rpin_n} <= fl[b];
         tick(12);
         cmp("data_lines_oe_o", 32'h0, {31'h0, oe_o});
      end
      cmp("mode_o", {31'h0, BFD_MD_ARRAY}, {31'h0, mode});
      rpin_n <= 1'b1;
      rnd = lfsr(rnd);
      burst(rnd[19:0], 3);
      cmp("burst_active_o", 32'h1, {31'h0, bact});
      burst(~rnd[19:0], 2);
      @(posedge clk_i);
      ce_n <= 1'b1;
      tick(12);
      cmp("burst_active_o", 32'h0, {31'h0, bact});
      cmp("data_lines_oe_o", 32'h0, {31'h0, oe_o});
      wp_n <= 1'b0;
      otp <= 1'b1;
      addr <= {8'hFF, rnd[11:0]};
      wr({rnd[31:8], 8'hF0}, 1'b1);
      cmp("mode_o", {31'h0, BFD_MD_ARRAY}, {31'h0, mode});
      cmp("array_otp_o", 32'h1, {31'h0, otp_o});
      test_done();
   end
endmodule
